// [rtl/init_pkg.sv]
// Package with constants and carrier types for the init and master reset sequencer.
package init_pkg;

  // ----------------------------------------------------------------
  // Timing constants.
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS        = 10;
  localparam int unsigned INIT_DURATION_NS     = 50000;
  localparam int unsigned INIT_DURATION_CYC    = INIT_DURATION_NS / CLK_PERIOD_NS;
  localparam int unsigned MIN_RESET_PULSE_NS   = 100;
  localparam int unsigned MIN_RESET_PULSE_CYC  =
    (MIN_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRELOAD_LEAD_CYC     = 2;
  localparam int unsigned COUNT_W              = 32;

  // ----------------------------------------------------------------
  // Field encodings and reset values.
  // ----------------------------------------------------------------
  localparam logic [1:0]  SR_NONE        = 2'h0;
  localparam logic [1:0]  SR_RESET       = 2'h1;
  localparam logic [1:0]  SR_SET         = 2'h2;
  localparam logic        HDFB_DEFAULT   = 1'b0;
  localparam logic        INPUT_PRELOAD  = 1'b1;

  typedef enum logic [2:0]
  {
    ST_OFF     = 3'h1,
    ST_INIT    = 3'h2,
    ST_RUN     = 3'h4
  } seq_state_t;

  typedef struct packed
  {
    logic       init_active;
    logic       outputs_enabled;
    logic       config_load;
    logic       preload_strobe;
  } seq_status_t;

endpackage : init_pkg

// [rtl/epld_init_master_reset.sv]
// Power-up and master reset initialization sequencer with register preload.
`timescale 1ns/1ps
// What this block does
// - Init holds outputs off, loads config, preloads.
// - Reset high: init finishes one duration after supply.
// - Reset low at power-up: outputs wait release.
// - Reset falling edge: outputs off, init restarts.
// - Early release: outputs enable only after duration.
// - Input registers and latches preload high.
// - Fast macrocell preload via set/reset term late.
// - Reset term preloads low, set term high.
// - Fast macrocell without term preloads high.
// - Dense macrocell preload from its config bit.
// - Unspecified dense preload bit gives low.
// - Per-macrocell power mode; unused blocks switched off.
// - Erase clears security bits and configuration.
module epld_init_master_reset
#(
  parameter int unsigned INIT_CYC  = init_pkg::INIT_DURATION_CYC,
  parameter int unsigned N_IN      = 12,
  parameter int unsigned N_FFB     = 18,
  parameter int unsigned N_HDFB    = 18,
  parameter int unsigned N_BLK     = 4,
  parameter int unsigned MC_PER_BLK = 9
)
(
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  input  wire logic                      clk_en,
  input  wire logic                      supply_ok,
  input  wire logic                      master_reset_n,
  input  wire logic                      erase,
  input  wire logic [N_FFB*2-1:0]        nv_ffb_sr_mode,
  input  wire logic [N_HDFB-1:0]         nv_hdfb_preload,
  input  wire logic [N_HDFB-1:0]         nv_hdfb_preload_spec,
  input  wire logic [N_BLK*MC_PER_BLK-1:0] nv_mc_used,
  input  wire logic [N_BLK*MC_PER_BLK-1:0] nv_mc_high_perf,
  input  wire logic [1:0]                nv_security,
  output init_pkg::seq_status_t          status,
  output logic                           out_enable,
  output logic [N_IN-1:0]                in_reg_preload,
  output logic [N_FFB-1:0]               ffb_sr_assert,
  output logic [N_FFB-1:0]               ffb_preload,
  output logic [N_HDFB-1:0]              hdfb_preload,
  output logic [N_BLK*MC_PER_BLK-1:0]    mc_high_perf,
  output logic [N_BLK-1:0]               blk_power_on,
  output logic [N_FFB*2-1:0]             cfg_ffb_sr_mode,
  output logic [N_HDFB-1:0]              cfg_hdfb_preload,
  output logic [1:0]                     security
);
  import init_pkg::*;

  localparam int unsigned N_MC = N_BLK * MC_PER_BLK;

  if (INIT_CYC <= PRELOAD_LEAD_CYC || N_IN == 0 || N_FFB == 0 || N_HDFB == 0 || N_MC == 0)
  begin : g_param_check
    $error("Parameter values not supported.");
  end

  // ----------------------------------------------------------------
  // Sequence state and counter.
  // ----------------------------------------------------------------
  seq_state_t            state;
  logic [COUNT_W-1:0]    count;
  logic                  mr_prev;
  logic                  init_done;
  logic                  mr_fall;

  assign mr_fall   = mr_prev && !master_reset_n;
  assign init_done = (count >= COUNT_W'(INIT_CYC));

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      mr_prev <= 1'b1;
    else if (clk_en)
      mr_prev <= master_reset_n;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ST_OFF;
      count <= '0;
    end
    else if (clk_en)
    begin
      if (!supply_ok)
      begin
        state <= ST_OFF;
        count <= '0;
      end
      else
      begin
        case (state)
          ST_OFF:
          begin
            state <= ST_INIT;
            count <= '0;
          end
          ST_INIT:
          begin
            if (mr_fall)
              count <= '0;
            else if (!init_done)
              count <= count + COUNT_W'(1);
            if (init_done && master_reset_n && !mr_fall)
              state <= ST_RUN;
          end
          ST_RUN:
          begin
            if (mr_fall)
            begin
              state <= ST_INIT;
              count <= '0;
            end
          end
          default:
          begin
            state <= ST_OFF;
            count <= '0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs held off until init completes and reset is released.
  // ----------------------------------------------------------------
  always_comb
  begin
    out_enable = (state == ST_RUN) && !mr_fall;
    status.init_active     = (state != ST_RUN);
    status.outputs_enabled = out_enable;
    status.config_load     = (state == ST_INIT) && (count == '0);
    status.preload_strobe  = (state == ST_INIT) &&
                             (count + COUNT_W'(PRELOAD_LEAD_CYC) >= COUNT_W'(INIT_CYC)) &&
                             !init_done;
  end

  // ----------------------------------------------------------------
  // Configuration held in the nonvolatile array.
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_ffb_sr_mode  <= '0;
      cfg_hdfb_preload <= '0;
      security         <= '0;
      mc_high_perf     <= '0;
      blk_power_on     <= '0;
    end
    else if (clk_en)
    begin
      if (erase)
      begin
        cfg_ffb_sr_mode  <= '0;
        cfg_hdfb_preload <= '0;
        security         <= '0;
        mc_high_perf     <= '0;
        blk_power_on     <= '0;
      end
      else if (status.config_load)
      begin
        cfg_ffb_sr_mode  <= nv_ffb_sr_mode;
        cfg_hdfb_preload <= nv_hdfb_preload & nv_hdfb_preload_spec;
        security         <= nv_security;
        mc_high_perf     <= nv_mc_high_perf & nv_mc_used;
        for (int b = 0; b < N_BLK; b++)
          blk_power_on[b] <= |nv_mc_used[b*MC_PER_BLK +: MC_PER_BLK];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register preload values.
  // ----------------------------------------------------------------
  function automatic logic ffb_value(input logic [1:0] mode);
    ffb_value = (mode == SR_RESET) ? 1'b0 : 1'b1;
  endfunction : ffb_value

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      in_reg_preload <= '1;
      ffb_sr_assert  <= '0;
      ffb_preload    <= '1;
      hdfb_preload   <= {N_HDFB{HDFB_DEFAULT}};
    end
    else if (clk_en)
    begin
      if (state != ST_RUN)
        in_reg_preload <= {N_IN{INPUT_PRELOAD}};
      for (int i = 0; i < N_FFB; i++)
      begin
        ffb_sr_assert[i] <= status.preload_strobe &&
                            (cfg_ffb_sr_mode[2*i +: 2] != SR_NONE);
        if (status.preload_strobe)
          ffb_preload[i] <= ffb_value(cfg_ffb_sr_mode[2*i +: 2]);
      end
      if (status.preload_strobe)
        hdfb_preload <= cfg_hdfb_preload;
    end
  end

  // ----------------------------------------------------------------
  // Assertions and covers.
  // ----------------------------------------------------------------
  a_outputs_off_init: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state != ST_RUN && !(clk_en && state == ST_INIT && init_done && master_reset_n))
    |=> !out_enable)
    else $error("Outputs enabled during init.");
  a_hold_while_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && state == ST_INIT && !master_reset_n) |=> state != ST_RUN)
    else $error("Left init while reset low.");
  a_fall_restarts: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && supply_ok && mr_fall) |=> (state == ST_INIT && count == '0))
    else $error("Falling reset did not restart.");
  a_early_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == ST_INIT && !init_done) |=> state != ST_RUN)
    else $error("Outputs enabled before init duration.");
  a_run_after_done: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && supply_ok && state == ST_INIT && init_done && master_reset_n && !mr_fall)
    |=> state == ST_RUN)
    else $error("Init did not complete.");
  a_sr_strobe: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && status.preload_strobe && cfg_ffb_sr_mode[1:0] == SR_RESET)
    |=> (ffb_sr_assert[0] && !ffb_preload[0]))
    else $error("Reset term preload wrong.");
  a_set_preload: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && status.preload_strobe && cfg_ffb_sr_mode[1:0] == SR_SET) |=> ffb_preload[0])
    else $error("Set term preload wrong.");
  a_none_preload: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && status.preload_strobe && cfg_ffb_sr_mode[1:0] == SR_NONE)
    |=> (ffb_preload[0] && !ffb_sr_assert[0]))
    else $error("Unused term preload wrong.");
  a_hdfb_preload: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && status.preload_strobe) |=> hdfb_preload == $past(cfg_hdfb_preload))
    else $error("Dense preload wrong.");
  a_erase_clears: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && erase) |=> (security == '0 && cfg_hdfb_preload == '0))
    else $error("Erase did not clear.");
  a_input_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clk_en && state == ST_INIT) |=> in_reg_preload == '1)
    else $error("Input preload not high.");

  c_power_up_run: cover property (@(posedge sys_clk) disable iff (!reset_n)
    state == ST_INIT ##1 state == ST_RUN);
  c_reinit: cover property (@(posedge sys_clk) disable iff (!reset_n)
    state == ST_RUN && mr_fall);
  c_late_release: cover property (@(posedge sys_clk) disable iff (!reset_n)
    state == ST_INIT && init_done && !master_reset_n);

endmodule : epld_init_master_reset

// [verification/sys_reset_model.sv]
// Model of the system reset logic that drives the master reset line.
`timescale 1ns/1ps
module sys_reset_model
(
  input  wire logic sys_clk,
  output logic      master_reset_n
);
  initial master_reset_n = 1'b1;
  // ----------------------------------------------------------------
  // Requests.
  // ----------------------------------------------------------------
  task automatic hold_low();
    @(posedge sys_clk);
    #1 master_reset_n = 1'b0;
  endtask : hold_low
  task automatic release_line();
    @(posedge sys_clk);
    #1 master_reset_n = 1'b1;
  endtask : release_line
  // The low time is exactly the requested cycle count; no minimum width is enforced.
  task automatic pulse(input int unsigned cycles);
    hold_low();
    repeat (cycles) @(posedge sys_clk);
    #1 master_reset_n = 1'b1;
  endtask : pulse
endmodule : sys_reset_model

// [verification/tb_top.sv]
// Self-checking testbench for the init and master reset sequencer.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
  import init_pkg::*;
  localparam int unsigned IC = 20;
  logic        sys_clk = 1'b0, reset_n = 1'b0, supply_ok = 1'b1, erase = 1'b0;
  logic        clk_en = 1'b1;
  logic        master_reset_n, out_enable;
  logic [7:0]  nv_ffb_sr_mode = 8'hE4;
  logic [3:0]  nv_hdfb_preload = 4'hA, nv_hdfb_preload_spec = 4'h6;
  logic [3:0]  nv_mc_used = 4'h3, nv_mc_high_perf = 4'hD, in_reg_preload;
  logic [3:0]  ffb_sr_assert, ffb_preload, hdfb_preload, mc_high_perf, cfg_hdfb_preload;
  logic [3:0]  sr_seen = 4'h0;
  logic [1:0]  nv_security = 2'h3, blk_power_on, security;
  logic [7:0]  cfg_ffb_sr_mode;
  seq_status_t status;
  int          fail_count = 0, tests_run = 0, cyc = 0, n;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) sr_seen <= sr_seen | ffb_sr_assert;
  sys_reset_model u_sys_reset_model (.sys_clk(sys_clk), .master_reset_n(master_reset_n));
  epld_init_master_reset #(.INIT_CYC(IC), .N_IN(4), .N_FFB(4), .N_HDFB(4), .N_BLK(2),
    .MC_PER_BLK(2)) u_epld_init_master_reset (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(clk_en), .supply_ok(supply_ok), .master_reset_n(master_reset_n), .erase(erase),
    .nv_ffb_sr_mode(nv_ffb_sr_mode), .nv_hdfb_preload(nv_hdfb_preload),
    .nv_hdfb_preload_spec(nv_hdfb_preload_spec), .nv_mc_used(nv_mc_used),
    .nv_mc_high_perf(nv_mc_high_perf), .nv_security(nv_security), .status(status),
    .out_enable(out_enable), .in_reg_preload(in_reg_preload),
    .ffb_sr_assert(ffb_sr_assert), .ffb_preload(ffb_preload),
    .hdfb_preload(hdfb_preload), .mc_high_perf(mc_high_perf),
    .blk_power_on(blk_power_on), .cfg_ffb_sr_mode(cfg_ffb_sr_mode),
    .cfg_hdfb_preload(cfg_hdfb_preload), .security(security));
  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic wait_oe(output int cnt);
    cnt = 0;
    while (out_enable !== 1'b1 && cnt < 200)
    begin
      @(posedge sys_clk);
      #1 cnt++;
    end
  endtask : wait_oe
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 `CHK("oe_in_init", 1'b0, out_enable)
    `CHK("init_active", 1'b1, status.init_active)
    `CHK("security_load", nv_security, security)
    wait_oe(n);
    `CHK("init_cycles", IC + 2 - 3, n)
    `CHK("in_preload", 4'hF, in_reg_preload)
    `CHK("sr_term_seen", 4'hE, sr_seen)
    `CHK("sr_term_idle", 4'h0, ffb_sr_assert)
    `CHK("ffb_preload", 4'hD, ffb_preload)
    `CHK("hdfb_preload", nv_hdfb_preload & nv_hdfb_preload_spec, hdfb_preload)
    `CHK("mc_perf", nv_mc_high_perf & nv_mc_used, mc_high_perf)
    `CHK("blk_power", 2'h1, blk_power_on)
    reset_n = 1'b0;
    u_sys_reset_model.hold_low();
    #1 reset_n = 1'b1;
    repeat (IC + 20) @(posedge sys_clk);
    #1 `CHK("oe_mr_low", 1'b0, out_enable)
    u_sys_reset_model.release_line();
    wait_oe(n);
    `CHK("rel_cycles", 1, n)
    fork
      u_sys_reset_model.pulse(MIN_RESET_PULSE_CYC);
      begin
        @(negedge master_reset_n);
        #1 `CHK("oe_fall", 1'b0, out_enable)
      end
    join
    repeat (IC - MIN_RESET_PULSE_CYC - 2) @(posedge sys_clk);
    #1 `CHK("oe_early_rel", 1'b0, out_enable)
    wait_oe(n);
    `CHK("restart_cycles", 4, n)
    supply_ok = 1'b0;
    nv_hdfb_preload_spec = 4'hF;
    nv_security = 2'h1;
    @(posedge sys_clk);
    #1 `CHK("oe_supply_low", 1'b0, out_enable)
    supply_ok = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 clk_en = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1 `CHK("oe_frozen", 1'b0, out_enable)
    clk_en = 1'b1;
    wait_oe(n);
    `CHK("frozen_cycles", IC, n)
    `CHK("hdfb_reload", 4'hA, hdfb_preload)
    `CHK("security_reload", 2'h1, security)
    erase = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 `CHK("erase_sec", 2'h0, security)
    `CHK("erase_ffb", 8'h00, cfg_ffb_sr_mode)
    `CHK("erase_hdfb", 4'h0, cfg_hdfb_preload)
    print_verdict();
  end
endmodule : tb_top
